// >>> rtl/pbec_top.sv
// bypass control register and three saturating read-clear event counters
// assumes event and link inputs synchronous to clk_i, one event per cycle each
`timescale 1ns/1ps
`include "pbec_cfg.svh"
module pbec_top
    import pbec_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        link_up_100_i,
    input  wire logic        link_up_1000_i,
    input  wire logic        rx_err_100_i,
    input  wire logic        rx_err_1000_i,
    input  wire logic        false_car_100_i,
    input  wire logic        false_car_1000_i,
    input  wire logic        copper_link_i,
    output logic             irq_o,
    output logic             tx_disable_o,
    output logic             byp_4b5b_o,
    output logic             byp_scram_o,
    output logic             byp_descram_o,
    output logic             byp_pcs_rx_o,
    output logic             byp_pcs_tx_o,
    output logic             byp_lfi_timer_o,
    output logic             no_mdix_forced_o,
    output logic             legacy_det_dis_o,
    output logic             mdix_dis_o,
    output logic             pol_corr_dis_o,
    output logic             honor_adv_o,
    output logic             pulse_filt_dis_o,
    output logic             np_auto_dis_o
);

    // ************************************************************
    // parameter check
    // ************************************************************
    // counters sit in the low half of a 32-bit register
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must be 1 to 16");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] v,
                                                  input logic inc, input logic clr);
        logic [CNT_W-1:0] base;
        base = clr ? '0 : v;
        // event in the clearing cycle is kept; saturate instead of wrap
        if (inc && base != CNT_MAX) begin
            cnt_step = base + 1'b1;
        end else begin
            cnt_step = base;
        end
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    pbec_bus_state_t  state_reg;
    pbec_bus_state_t  state_next;
    logic [15:0]      ctrl_reg;
    logic [15:0]      ctrl_next;
    logic [2:0]       stat_reg;
    logic [2:0]       stat_next;
    logic [2:0]       mask_reg;
    logic [2:0]       mask_next;
    logic             link_prev_reg;
    logic [CNT_W-1:0] cnt_reg [`PBEC_NCNT];
    logic [`PBEC_NCNT-1:0] cnt_inc;
    logic [`PBEC_NCNT-1:0] cnt_clr;
    logic [31:0]      rd_data;

    wire       take      = wb_cyc_i && wb_stb_i && state_reg == PBEC_IDLE;
    wire [5:0] idx       = wb_adr_i[7:2];
    wire       wr        = take && wb_we_i;
    wire       rd        = take && !wb_we_i;
    wire       hit_ctrl  = idx == `PBEC_IDX_CTRL;
    wire       hit_istat = idx == `PBEC_IDX_ISTAT;
    wire       hit_imask = idx == `PBEC_IDX_IMASK;
    wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // taken only from idle, so a strobe held through ack is not taken twice
    always_comb begin
        case (state_reg)
            PBEC_IDLE: begin
                state_next = take ? PBEC_ACK : PBEC_IDLE;
            end
            PBEC_ACK: begin
                state_next = PBEC_IDLE;
            end
            default: begin
                state_next = PBEC_IDLE;
            end
        endcase
    end

    // ************************************************************
    // counter events
    // ************************************************************
    // gate each speed with its own link
    assign cnt_inc[`PBEC_CNT_RXE] = (rx_err_100_i && link_up_100_i)
                                  || (rx_err_1000_i && link_up_1000_i); // see R1
    assign cnt_inc[`PBEC_CNT_FC]  = (false_car_100_i && link_up_100_i)
                                  || (false_car_1000_i && link_up_1000_i); // see R3
    assign cnt_inc[`PBEC_CNT_LD]  = link_prev_reg && !copper_link_i; // see R4

    assign cnt_clr[`PBEC_CNT_RXE] = rd && idx == `PBEC_IDX_RXE; // see R2
    assign cnt_clr[`PBEC_CNT_FC]  = rd && idx == `PBEC_IDX_FC;  // see R2
    assign cnt_clr[`PBEC_CNT_LD]  = rd && idx == `PBEC_IDX_LD;  // see R2

    genvar gi;
    for (gi = 0; gi < `PBEC_NCNT; gi++) begin : g_cnt
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_reg[gi] <= '0;
            end else begin
                cnt_reg[gi] <= cnt_step(cnt_reg[gi], cnt_inc[gi], cnt_clr[gi]); // see R2
            end
        end
    end

    // ************************************************************
    // control, status and mask
    // ************************************************************
    // reserved control bits never store, so they read zero
    assign ctrl_next = (wr && hit_ctrl)
                     ? (ctrl_reg & ~(lane_mask & `PBEC_CTRL_WMASK))
                       | (wb_dat_i[15:0] & lane_mask & `PBEC_CTRL_WMASK) // see R15
                     : ctrl_reg;

    // new events win over the read that clears
    assign stat_next = ((rd && hit_istat) ? 3'h0 : stat_reg) | cnt_inc;
    assign mask_next = (wr && hit_imask && wb_sel_i[0]) ? wb_dat_i[2:0] : mask_reg;

    function automatic logic [15:0] cnt_word(input logic [CNT_W-1:0] v);
        cnt_word = 16'h0000;
        cnt_word[CNT_W-1:0] = v; // see R15
    endfunction

    assign rd_data = hit_ctrl                 ? {16'h0000, ctrl_reg}
                   : (idx == `PBEC_IDX_RXE)   ? {16'h0000, cnt_word(cnt_reg[`PBEC_CNT_RXE])}
                   : (idx == `PBEC_IDX_FC)    ? {16'h0000, cnt_word(cnt_reg[`PBEC_CNT_FC])} // see R3
                   : (idx == `PBEC_IDX_LD)    ? {16'h0000, cnt_word(cnt_reg[`PBEC_CNT_LD])}
                   : hit_istat                ? {29'h0, stat_reg}
                   : hit_imask                ? {29'h0, mask_reg}
                   : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `PBEC_CTRL_RST; // see R8
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg      <= 3'h0;
            mask_reg      <= 3'h0;
            irq_o         <= 1'b0;
            link_prev_reg <= 1'b0;
        end else begin
            stat_reg      <= stat_next;
            mask_reg      <= mask_next;
            irq_o         <= |(stat_next & mask_next);
            link_prev_reg <= copper_link_i;
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    // one wait state keeps read data registered and read clears clean
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= PBEC_IDLE;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            wb_ack_o  <= state_next == PBEC_ACK;
            if (rd) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // ************************************************************
    // control outputs
    // ************************************************************
    assign tx_disable_o     = ctrl_reg[`PBEC_B_TXDIS];  // see R5
    assign byp_4b5b_o       = ctrl_reg[`PBEC_B_4B5B];   // see R6
    assign byp_scram_o      = ctrl_reg[`PBEC_B_SCR];    // see R6
    assign byp_descram_o    = ctrl_reg[`PBEC_B_DSCR];   // see R6
    assign byp_pcs_rx_o     = ctrl_reg[`PBEC_B_PCSRX];  // see R6
    assign byp_pcs_tx_o     = ctrl_reg[`PBEC_B_PCSTX];  // see R6
    assign byp_lfi_timer_o  = ctrl_reg[`PBEC_B_LFIT];   // see R7
    assign no_mdix_forced_o = ctrl_reg[`PBEC_B_MDIXF];  // see R8
    assign legacy_det_dis_o = ctrl_reg[`PBEC_B_LEGDET]; // see R9
    assign mdix_dis_o       = ctrl_reg[`PBEC_B_MDIXD];  // see R10
    assign pol_corr_dis_o   = ctrl_reg[`PBEC_B_POLD];   // see R11
    assign honor_adv_o      = ctrl_reg[`PBEC_B_ADV];    // see R12
    assign pulse_filt_dis_o = ctrl_reg[`PBEC_B_PSF];    // see R13
    assign np_auto_dis_o    = ctrl_reg[`PBEC_B_NP];     // see R14

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ctr_saturate_a: assert property ( // see R2
        cnt_reg[`PBEC_CNT_RXE] == CNT_MAX && !cnt_clr[`PBEC_CNT_RXE]
        |=> cnt_reg[`PBEC_CNT_RXE] == CNT_MAX)
        else $error("receive error counter left saturation");

    rxe_count_a: assert property ( // see R1
        cnt_inc[`PBEC_CNT_RXE] && !cnt_clr[`PBEC_CNT_RXE] && cnt_reg[`PBEC_CNT_RXE] != CNT_MAX
        |=> cnt_reg[`PBEC_CNT_RXE] == $past(cnt_reg[`PBEC_CNT_RXE]) + 1'b1)
        else $error("receive error not counted");

    rxe_gate_a: assert property ( // see R1
        !link_up_100_i && !link_up_1000_i && !cnt_clr[`PBEC_CNT_RXE]
        |=> $stable(cnt_reg[`PBEC_CNT_RXE]))
        else $error("receive error counted without link");

    fc_count_a: assert property ( // see R3
        false_car_1000_i && link_up_1000_i && !cnt_clr[`PBEC_CNT_FC] && cnt_reg[`PBEC_CNT_FC] != CNT_MAX
        |=> cnt_reg[`PBEC_CNT_FC] == $past(cnt_reg[`PBEC_CNT_FC]) + 1'b1)
        else $error("false carrier not counted");

    link_drop_a: assert property ( // see R4
        $fell(copper_link_i) && !cnt_clr[`PBEC_CNT_LD] && cnt_reg[`PBEC_CNT_LD] != CNT_MAX
        |=> cnt_reg[`PBEC_CNT_LD] == $past(cnt_reg[`PBEC_CNT_LD]) + 1'b1)
        else $error("link drop not counted");

    read_clear_a: assert property ( // see R2
        cnt_clr[`PBEC_CNT_LD] && !cnt_inc[`PBEC_CNT_LD]
        |=> wb_ack_o && cnt_reg[`PBEC_CNT_LD] == '0 && wb_dat_o[15:0] == $past(cnt_word(cnt_reg[`PBEC_CNT_LD])))
        else $error("counter read did not return and clear");

    ctrl_reset_a: assert property ( // see R12
        $fell(rst_i) |-> ctrl_reg == `PBEC_CTRL_RST && no_mdix_forced_o && honor_adv_o && !tx_disable_o)
        else $error("control reset value wrong");

    rsvd_zero_a: assert property ( // see R15
        wb_ack_o |-> ctrl_reg[`PBEC_B_RSV_HI] == 1'b0 && ctrl_reg[`PBEC_B_RSV_LO] == 1'b0
                     && wb_dat_o[31:16] == 16'h0000)
        else $error("reserved bits not zero");

    ack_single_a: assert property (
        take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");

    // ************************************************************
    // counter, status, interrupt and decode checks
    // ************************************************************
    rxe_fast_a: assert property ( // see R1
        rx_err_1000_i && link_up_1000_i && !cnt_clr[`PBEC_CNT_RXE] && cnt_reg[`PBEC_CNT_RXE] != CNT_MAX
        |=> cnt_reg[`PBEC_CNT_RXE] == $past(cnt_reg[`PBEC_CNT_RXE]) + 1'b1)
        else $error("gigabit receive error not counted");

    rxe_slow_a: assert property ( // see R1
        rx_err_100_i && link_up_100_i && !cnt_clr[`PBEC_CNT_RXE] && cnt_reg[`PBEC_CNT_RXE] != CNT_MAX
        |=> cnt_reg[`PBEC_CNT_RXE] == $past(cnt_reg[`PBEC_CNT_RXE]) + 1'b1)
        else $error("fast ethernet receive error not counted");

    rxe_clear_a: assert property ( // see R2
        cnt_clr[`PBEC_CNT_RXE] && !cnt_inc[`PBEC_CNT_RXE]
        |=> cnt_reg[`PBEC_CNT_RXE] == '0
            && wb_dat_o[15:0] == $past(cnt_word(cnt_reg[`PBEC_CNT_RXE])))
        else $error("receive error read did not return and clear");

    fc_slow_a: assert property ( // see R3
        false_car_100_i && link_up_100_i && !cnt_clr[`PBEC_CNT_FC] && cnt_reg[`PBEC_CNT_FC] != CNT_MAX
        |=> cnt_reg[`PBEC_CNT_FC] == $past(cnt_reg[`PBEC_CNT_FC]) + 1'b1)
        else $error("fast ethernet false carrier not counted");

    fc_gate_a: assert property ( // see R3
        !link_up_100_i && !link_up_1000_i && !cnt_clr[`PBEC_CNT_FC]
        |=> $stable(cnt_reg[`PBEC_CNT_FC]))
        else $error("false carrier counted without link");

    fc_saturate_a: assert property ( // see R2
        cnt_reg[`PBEC_CNT_FC] == CNT_MAX && !cnt_clr[`PBEC_CNT_FC]
        |=> cnt_reg[`PBEC_CNT_FC] == CNT_MAX)
        else $error("false carrier counter left saturation");

    fc_clear_a: assert property ( // see R2
        cnt_clr[`PBEC_CNT_FC] && !cnt_inc[`PBEC_CNT_FC]
        |=> cnt_reg[`PBEC_CNT_FC] == '0
            && wb_dat_o[15:0] == $past(cnt_word(cnt_reg[`PBEC_CNT_FC])))
        else $error("false carrier read did not return and clear");

    ld_quiet_a: assert property ( // see R4
        !$fell(copper_link_i) && !cnt_clr[`PBEC_CNT_LD]
        |=> $stable(cnt_reg[`PBEC_CNT_LD]))
        else $error("link drop counted without a drop");

    ld_saturate_a: assert property ( // see R2
        cnt_reg[`PBEC_CNT_LD] == CNT_MAX && !cnt_clr[`PBEC_CNT_LD]
        |=> cnt_reg[`PBEC_CNT_LD] == CNT_MAX)
        else $error("link drop counter left saturation");

    status_set_a: assert property ( // see R1 R3 R4
        |cnt_inc
        |=> (stat_reg & $past(cnt_inc)) == $past(cnt_inc))
        else $error("event did not set its status bit");

    irq_level_a: assert property (
        irq_o == |(stat_reg & mask_reg))
        else $error("interrupt level wrong");

    unmapped_zero_a: assert property ( // see R15
        rd && (idx < `PBEC_IDX_CTRL || idx > `PBEC_IDX_IMASK)
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // ************************************************************
    // control checks
    // ************************************************************
    ctrl_idle_a: assert property ( // see R5
        !(wr && hit_ctrl)
        |=> $stable(ctrl_reg))
        else $error("control changed without a write");

    lane_hold_a: assert property ( // see R6
        wr && hit_ctrl && !wb_sel_i[1]
        |=> ctrl_reg[`PBEC_B_TXDIS:`PBEC_B_RSV_HI] == $past(ctrl_reg[`PBEC_B_TXDIS:`PBEC_B_RSV_HI]))
        else $error("unselected lane changed");

    txdis_write_a: assert property ( // see R5
        wr && hit_ctrl && wb_sel_i[1]
        |=> tx_disable_o == $past(wb_dat_i[`PBEC_B_TXDIS]))
        else $error("transmit disable not written");

    bypass_write_a: assert property ( // see R6
        wr && hit_ctrl && wb_sel_i[1]
        |=> {byp_4b5b_o, byp_scram_o, byp_descram_o, byp_pcs_rx_o, byp_pcs_tx_o}
            == $past(wb_dat_i[`PBEC_B_4B5B:`PBEC_B_PCSTX]))
        else $error("bypass bits not written");

    lfi_write_a: assert property ( // see R7
        wr && hit_ctrl && wb_sel_i[1]
        |=> byp_lfi_timer_o == $past(wb_dat_i[`PBEC_B_LFIT]))
        else $error("inhibit timer bypass not written");

    forced_write_a: assert property ( // see R8
        wr && hit_ctrl && wb_sel_i[0]
        |=> no_mdix_forced_o == $past(wb_dat_i[`PBEC_B_MDIXF]))
        else $error("forced crossover bit not written");

    legacy_write_a: assert property ( // see R9
        wr && hit_ctrl && wb_sel_i[0]
        |=> legacy_det_dis_o == $past(wb_dat_i[`PBEC_B_LEGDET]))
        else $error("legacy detect bit not written");

    mdix_write_a: assert property ( // see R10
        wr && hit_ctrl && wb_sel_i[0]
        |=> mdix_dis_o == $past(wb_dat_i[`PBEC_B_MDIXD]))
        else $error("crossover disable not written");

    polarity_write_a: assert property ( // see R11
        wr && hit_ctrl && wb_sel_i[0]
        |=> pol_corr_dis_o == $past(wb_dat_i[`PBEC_B_POLD]))
        else $error("polarity bit not written");

    adv_write_a: assert property ( // see R12
        wr && hit_ctrl && wb_sel_i[0]
        |=> honor_adv_o == $past(wb_dat_i[`PBEC_B_ADV]))
        else $error("advertised ability bit not written");

    filter_write_a: assert property ( // see R13
        wr && hit_ctrl && wb_sel_i[0]
        |=> pulse_filt_dis_o == $past(wb_dat_i[`PBEC_B_PSF]))
        else $error("pulse filter bit not written");

    nextpage_write_a: assert property ( // see R14
        wr && hit_ctrl && wb_sel_i[0]
        |=> np_auto_dis_o == $past(wb_dat_i[`PBEC_B_NP]))
        else $error("next page bit not written");

endmodule

// >>> shared/pbec_cfg.svh
// constants of the bypass control and event counter register bank
// assumes a 32-bit classic wishbone slave, byte address = 4 * index
// How it works
// R1: one 8-bit receive error counter, counts at 100 or 1000 only with link up.
// R2: all three counters hold at 255, and a read returns then zeroes them.
// R3: one 8-bit false carrier counter, gated by its link, upper byte reads zero.
// R4: link disconnect counter counts every copper link loss at any speed.
// R5: control bit 15 stops transmit output onto the media, resets to zero.
// R6: control bits 14 to 10 bypass 4b5b, scrambler, descrambler, pcs rx, pcs tx.
// R7: control bit 9 skips the link fail inhibit timer, resets to zero.
// R8: control bit 7 stops crossover in forced 10/100 modes, resets to one.
// R9: control bit 6 disables legacy gigabit partner detection, resets to zero.
// R10: control bit 5 disables crossover correction in all modes, resets to zero.
// R11: control bit 4 stops pair polarity correction, resets to zero.
// R12: control bit 3 one honours advertised abilities in parallel detect, resets one.
// R13: control bit 2 removes the 0.75/0.25 gigabit pulse shaping filter.
// R14: control bit 1 stops automatic gigabit next page exchange, resets to zero.
// R15: reserved bits of all six registers read zero and ignore writes.
`ifndef PBEC_CFG_SVH
`define PBEC_CFG_SVH
`define PBEC_IDX_CTRL   6'h12
`define PBEC_IDX_RXE    6'h13
`define PBEC_IDX_FC     6'h14
`define PBEC_IDX_LD     6'h15
`define PBEC_IDX_ISTAT  6'h16
`define PBEC_IDX_IMASK  6'h17
`define PBEC_CTRL_RST   16'h0088
`define PBEC_CTRL_WMASK 16'hFEFE
`define PBEC_CNT_RXE    0
`define PBEC_CNT_FC     1
`define PBEC_CNT_LD     2
`define PBEC_NCNT       3
`define PBEC_B_TXDIS    15
`define PBEC_B_4B5B     14
`define PBEC_B_SCR      13
`define PBEC_B_DSCR     12
`define PBEC_B_PCSRX    11
`define PBEC_B_PCSTX    10
`define PBEC_B_LFIT     9
`define PBEC_B_MDIXF    7
`define PBEC_B_LEGDET   6
`define PBEC_B_MDIXD    5
`define PBEC_B_POLD     4
`define PBEC_B_ADV      3
`define PBEC_B_PSF      2
`define PBEC_B_NP       1
`define PBEC_B_RSV_HI   8
`define PBEC_B_RSV_LO   0
`endif

// >>> shared/pbec_pkg.sv
// types of the bypass control and event counter register bank
// assumes nothing beyond the constants header
package pbec_pkg;
    typedef enum logic [1:0] {
        PBEC_IDLE = 2'b00,
        PBEC_ACK  = 2'b01
    } pbec_bus_state_t;
endpackage

// >>> tb/pbec_station.sv
// wishbone master standing in for the management station
// assumes clk_i is shared with the block and a classic single-cycle slave
`timescale 1ns/1ps
module pbec_station (
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic      [7:0]  wb_adr_o,
    output logic      [3:0]  wb_sel_o,
    output logic      [31:0] wb_dat_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // request stands until ack is sampled; release gives one idle cycle before the next
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= wdat;
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
    endtask
endmodule

// >>> tb/pbec_top_bench.sv
// self-checking bench of the bypass control and event counter bank
// assumes the station model as bus master and one 250 MHz clock
`timescale 1ns/1ps
module pbec_top_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [6:0]  ev = 7'h00;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] pins;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // ****************************************
    // clock, block and station
    // ****************************************
    initial forever #2 clk_i = ~clk_i;
    pbec_top pbec_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link_up_100_i(ev[0]), .link_up_1000_i(ev[1]), .rx_err_100_i(ev[2]), .rx_err_1000_i(ev[3]),
        .false_car_100_i(ev[4]), .false_car_1000_i(ev[5]), .copper_link_i(ev[6]), .irq_o(irq),
        .tx_disable_o(pins[15]), .byp_4b5b_o(pins[14]), .byp_scram_o(pins[13]),
        .byp_descram_o(pins[12]), .byp_pcs_rx_o(pins[11]), .byp_pcs_tx_o(pins[10]),
        .byp_lfi_timer_o(pins[9]), .no_mdix_forced_o(pins[7]), .legacy_det_dis_o(pins[6]),
        .mdix_dis_o(pins[5]), .pol_corr_dis_o(pins[4]), .honor_adv_o(pins[3]),
        .pulse_filt_dis_o(pins[2]), .np_auto_dis_o(pins[1]));
    assign pins[8] = 1'b0;
    assign pins[0] = 1'b0;
    pbec_station pbec_station_i (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        pbec_station_i.xfer(1'b0, a, 4'h0, 32'h0, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] unused;
        pbec_station_i.xfer(1'b1, a, s, d, unused);
    endtask
    // hold event vector v for n cycles
    task automatic set(input logic [6:0] v, input int n);
        @(posedge clk_i);
        ev <= v;
        repeat (n - 1) @(posedge clk_i);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // limit of roughly forty times the expected run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_ctrl();
        rd(8'h48, q);
        chk("ctrl reset", 32'h0088, q);
        chk("ctrl pins reset", 32'h0088, {16'h0, pins});
        for (int i = 0; i < 16; i++) begin
            wr(8'h48, 4'h3, 32'hFFFF0000 | (32'h1 << i));
            rd(8'h48, q);
            chk("ctrl walk", (32'h1 << i) & 32'hFEFE, q);
            chk("ctrl walk pins", (32'h1 << i) & 32'hFEFE, {16'h0, pins});
        end
        wr(8'h48, 4'h1, 32'hFFFF);
        rd(8'h48, q);
        chk("ctrl low lane", 32'h80FE, q);
        $display("control test done");
    endtask
    task automatic t_rxe();
        set(7'h05, 3);
        set(7'h08, 2);
        set(7'h0A, 1);
        set(7'h0C, 2);
        set(7'h00, 2);
        rd(8'h4C, q);
        chk("rx error count", 32'h4, q);
        rd(8'h4C, q);
        chk("rx error cleared", 32'h0, q);
        $display("receive error test done");
    endtask
    task automatic t_fc();
        set(7'h22, 300);
        set(7'h10, 3);
        set(7'h00, 2);
        rd(8'h50, q);
        chk("false carrier sat", 32'hFF, q);
        rd(8'h50, q);
        chk("false carrier cleared", 32'h0, q);
        $display("false carrier test done");
    endtask
    task automatic t_ld();
        for (int i = 0; i < 3; i++) begin
            set(7'h40, 2);
            set(7'h03, 2);
        end
        rd(8'h54, q);
        chk("link drops", 32'h3, q);
        rd(8'h54, q);
        chk("link drops cleared", 32'h0, q);
        rd(8'h80, q);
        chk("unmapped read", 32'h0, q);
        $display("link drop test done");
    endtask
    task automatic t_irq();
        wr(8'h5C, 4'h1, 32'h0);
        settle();
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h5C, 4'h1, 32'h1);
        settle();
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(8'h58, q);
        chk("status", 32'h7, q);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(8'h5C, 4'h1, 32'h2);
        set(7'h11, 1);
        set(7'h00, 1);
        settle();
        chk("irq carrier", 32'h1, {31'h0, irq});
        rd(8'h58, q);
        chk("status carrier", 32'h2, q);
        $display("interrupt test done");
    endtask
    // reset in mid-run with the control word changed and errors counted
    task automatic t_reset();
        wr(8'h48, 4'h3, 32'hFFFF);
        set(7'h05, 2);
        @(posedge clk_i);
        ev    <= 7'h00;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h48, q);
        chk("ctrl after reset", 32'h0088, q);
        rd(8'h4C, q);
        chk("rx error after reset", 32'h0, q);
        rd(8'h58, q);
        chk("status after reset", 32'h0, q);
        $display("reset test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ctrl();
        t_rxe();
        t_fc();
        t_ld();
        t_irq();
        t_reset();
        conclude();
    end
endmodule
